// ### acvb_bank.sv
// acvb_bank: plus-side and minus-side calibration value registers on apb
// assumes: apb master on clk; calibration engine drives cal_busy and results
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module acvb_bank
  import acvb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cal_busy,
  input  wire logic [5:0]  plus_cal_d_term_res,
  input  wire logic [5:0]  plus_cal_s_term_res,
  input  wire logic [9:0]  plus_cal_term_four_res,
  input  wire logic [8:0]  plus_cal_term_three_res,
  input  wire logic [7:0]  plus_cal_term_two_res,
  input  wire logic [6:0]  plus_cal_term_one_res,
  input  wire logic [5:0]  plus_cal_term_zero_res,
  input  wire logic [5:0]  minus_cal_d_term_res,
  input  wire logic [5:0]  minus_cal_s_term_res,
  input  wire logic [9:0]  minus_cal_term_four_res,
  input  wire logic [8:0]  minus_cal_term_three_res,
  input  wire logic [7:0]  minus_cal_term_two_res,
  input  wire logic [6:0]  minus_cal_term_one_res,
  input  wire logic [5:0]  minus_cal_term_zero_res,
  output logic      [5:0]  plus_cal_d_term,
  output logic      [5:0]  plus_cal_s_term,
  output logic      [9:0]  plus_cal_term_four,
  output logic      [8:0]  plus_cal_term_three,
  output logic      [7:0]  plus_cal_term_two,
  output logic      [6:0]  plus_cal_term_one,
  output logic      [5:0]  plus_cal_term_zero,
  output logic      [5:0]  minus_cal_d_term,
  output logic      [5:0]  minus_cal_s_term,
  output logic      [9:0]  minus_cal_term_four,
  output logic      [8:0]  minus_cal_term_three,
  output logic      [7:0]  minus_cal_term_two,
  output logic      [6:0]  minus_cal_term_one,
  output logic      [5:0]  minus_cal_term_zero
);

  // ==========================================================================
  // result and value arrays
  logic [9:0] res_a [ACVB_NVAL];
  logic [9:0] val_a [ACVB_NVAL];
  logic       end_pulse;
  logic       wr_fire;

  assign res_a[IDX_P_D]  = 10'(plus_cal_d_term_res);
  assign res_a[IDX_P_S]  = 10'(plus_cal_s_term_res);
  assign res_a[IDX_P_T4] = 10'(plus_cal_term_four_res);
  assign res_a[IDX_P_T3] = 10'(plus_cal_term_three_res);
  assign res_a[IDX_P_T2] = 10'(plus_cal_term_two_res);
  assign res_a[IDX_P_T1] = 10'(plus_cal_term_one_res);
  assign res_a[IDX_P_T0] = 10'(plus_cal_term_zero_res);
  assign res_a[IDX_M_D]  = 10'(minus_cal_d_term_res);
  assign res_a[IDX_M_S]  = 10'(minus_cal_s_term_res);
  assign res_a[IDX_M_T4] = 10'(minus_cal_term_four_res);
  assign res_a[IDX_M_T3] = 10'(minus_cal_term_three_res);
  assign res_a[IDX_M_T2] = 10'(minus_cal_term_two_res);
  assign res_a[IDX_M_T1] = 10'(minus_cal_term_one_res);
  assign res_a[IDX_M_T0] = 10'(minus_cal_term_zero_res);

  // ==========================================================================
  // value outputs to the converter
  assign plus_cal_d_term      = val_a[IDX_P_D][WID_D-1:0];
  assign plus_cal_s_term      = val_a[IDX_P_S][WID_S-1:0];
  assign plus_cal_term_four   = val_a[IDX_P_T4][WID_T4-1:0];
  assign plus_cal_term_three  = val_a[IDX_P_T3][WID_T3-1:0];
  assign plus_cal_term_two    = val_a[IDX_P_T2][WID_T2-1:0];
  assign plus_cal_term_one    = val_a[IDX_P_T1][WID_T1-1:0];
  assign plus_cal_term_zero   = val_a[IDX_P_T0][WID_T0-1:0];
  assign minus_cal_d_term     = val_a[IDX_M_D][WID_D-1:0];
  assign minus_cal_s_term     = val_a[IDX_M_S][WID_S-1:0];
  assign minus_cal_term_four  = val_a[IDX_M_T4][WID_T4-1:0];
  assign minus_cal_term_three = val_a[IDX_M_T3][WID_T3-1:0];
  assign minus_cal_term_two   = val_a[IDX_M_T2][WID_T2-1:0];
  assign minus_cal_term_one   = val_a[IDX_M_T1][WID_T1-1:0];
  assign minus_cal_term_zero  = val_a[IDX_M_T0][WID_T0-1:0];

  // ==========================================================================
  // end of calibration
  acvb_cal_end u_cal_end (
    .clk       (clk),
    .rstn      (rstn),
    .cal_busy  (cal_busy),
    .end_pulse (end_pulse)
  );

  // ==========================================================================
  // apb slave state
  acvb_apb_st_t st_q;
  acvb_apb_st_t st_d;
  logic [4:0]   idx_q;
  logic [4:0]   idx_d;
  logic         pready_q;
  logic         pready_d;
  logic         pslverr_q;
  logic         pslverr_d;
  logic [31:0]  prdata_q;
  logic [31:0]  prdata_d;

  function automatic logic [15:0] acvb_merge(logic [15:0] old, logic [31:0] wd,
                                             logic [3:0] strb);
    logic [15:0] m;
    m = old;
    if (strb[0]) m[7:0] = wd[7:0];
    if (strb[1]) m[15:8] = wd[15:8];
    return m;
  endfunction

  always_comb begin
    st_d      = st_q;
    idx_d     = idx_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    prdata_d  = 32'h0000_0000;
    case (st_q)
      ST_IDLE: begin
        if (psel && !penable) begin
          idx_d = acvb_decode(paddr);
          st_d  = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (psel && penable) begin
          pready_d  = 1'b1;
          pslverr_d = (idx_q == ACVB_NONE);
          if (!pwrite && idx_q != ACVB_NONE) begin
            prdata_d = 32'(val_a[idx_q[3:0]]);
          end
          st_d = ST_DONE;
        end
      end
      ST_DONE: begin
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q      <= ST_IDLE;
      idx_q     <= ACVB_NONE;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      st_q      <= st_d;
      idx_q     <= idx_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign wr_fire = (st_q == ST_DONE) && pready_q && psel && penable && pwrite
                   && (idx_q != ACVB_NONE);

  // ==========================================================================
  // value registers, widths per term
  for (genvar g = 0; g < ACVB_NVAL; g++) begin : g_val
    localparam int unsigned W = acvb_width(g);
    logic [W-1:0] q;
    logic [15:0]  merged;

    assign merged = acvb_merge(16'(val_a[g]), pwdata, pstrb);

    acvb_value_reg #(
      .W (W)
    ) u_val (
      .clk      (clk),
      .rstn     (rstn),
      .load     (end_pulse),
      .load_val (res_a[g][W-1:0]),
      .wr_en    (wr_fire && (idx_q == 5'(g))),
      .wr_val   (merged[W-1:0]),
      .val_q    (q)
    );

    assign val_a[g] = 10'(q);
  end

  // ==========================================================================
  // check helpers
  logic       wchk_q;
  logic [4:0] wchk_idx_q;
  logic [9:0] wchk_val_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wchk_q     <= 1'b0;
      wchk_idx_q <= 5'h00;
      wchk_val_q <= 10'h000;
    end else begin
      wchk_q     <= wr_fire && !end_pulse && (pstrb[1:0] == 2'h3);
      wchk_idx_q <= idx_q;
      wchk_val_q <= 10'(pwdata[9:0] & acvb_mask(32'(idx_q)));
    end
  end

  // ==========================================================================
  // checks
  sequence s_setup;
    (st_q == ST_IDLE) && psel && !penable;
  endsequence

  sequence s_answer;
    !pready ##1 pready;
  endsequence

  a_access_wait: assert property (@(posedge clk) disable iff (!rstn)
    s_setup ##1 (psel && penable) |-> s_answer) else $error("apb answer not after one wait");

  a_rsvd_zero: assert property (@(posedge clk) disable iff (!rstn)
    (pready && !pslverr) |-> ((prdata & ~acvb_mask(32'(idx_q))) == 32'h0000_0000))
    else $error("reserved bits read non-zero");

  a_plus_load: assert property (@(posedge clk) disable iff (!rstn)
    end_pulse |=> (val_a[IDX_P_T4] == $past(res_a[IDX_P_T4]))
                  && (val_a[IDX_P_D] == $past(res_a[IDX_P_D])))
    else $error("plus-side values not loaded at calibration end");

  a_minus_load: assert property (@(posedge clk) disable iff (!rstn)
    end_pulse |=> (val_a[IDX_M_T3] == $past(res_a[IDX_M_T3]))
                  && (val_a[IDX_M_T0] == $past(res_a[IDX_M_T0])))
    else $error("minus-side values not loaded at calibration end");

  a_write_takes: assert property (@(posedge clk) disable iff (!rstn)
    wchk_q |-> (val_a[wchk_idx_q[3:0]] == wchk_val_q)) else $error("write not stored");

  a_unmapped_err: assert property (@(posedge clk) disable iff (!rstn)
    (s_setup and (acvb_decode(paddr) == ACVB_NONE)) ##1 (psel && penable)
      |=> (pready && pslverr && prdata == 32'h0000_0000))
    else $error("unmapped access not refused");

  a_idle_quiet: assert property (@(posedge clk) disable iff (!rstn)
    (st_q == ST_IDLE) |-> !pready && !pslverr) else $error("answer outside access");

  a_rdata_quiet: assert property (@(posedge clk) disable iff (!rstn)
    !pready |-> (prdata == 32'h0000_0000)) else $error("read data outside answer");

  a_answer_pulse: assert property (@(posedge clk) disable iff (!rstn)
    pready |=> !pready) else $error("answer lasted two cycles");

  a_plus_rest: assert property (@(posedge clk) disable iff (!rstn)
    end_pulse |=> (val_a[IDX_P_S] == $past(res_a[IDX_P_S]))
                  && (val_a[IDX_P_T3] == $past(res_a[IDX_P_T3]))
                  && (val_a[IDX_P_T2] == $past(res_a[IDX_P_T2]))
                  && (val_a[IDX_P_T1] == $past(res_a[IDX_P_T1]))
                  && (val_a[IDX_P_T0] == $past(res_a[IDX_P_T0])))
    else $error("plus-side terms not loaded at calibration end");

  a_minus_rest: assert property (@(posedge clk) disable iff (!rstn)
    end_pulse |=> (val_a[IDX_M_D] == $past(res_a[IDX_M_D]))
                  && (val_a[IDX_M_S] == $past(res_a[IDX_M_S]))
                  && (val_a[IDX_M_T4] == $past(res_a[IDX_M_T4]))
                  && (val_a[IDX_M_T2] == $past(res_a[IDX_M_T2]))
                  && (val_a[IDX_M_T1] == $past(res_a[IDX_M_T1])))
    else $error("minus-side terms not loaded at calibration end");

endmodule
`default_nettype wire

// ### acvb_bank_bench.sv
// acvb_bank_bench: self-checking bench of the calibration value bank
// assumes: acvb_pkg and acvb_bank compiled before it; bench acts as apb master
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fails++; \
  $display("ERROR %0t: got %h expected %h", $time, (got), (exp)); end end
module acvb_bank_bench
  import acvb_pkg::*;
();
  // ==========================================================================
  // signals and tables
  typedef struct packed {
    logic [4:0]  idx;
    logic [31:0] d;
    logic [3:0]  s;
    logic [9:0]  e;
  } acvb_row_t;
  logic        clk, rstn, psel, penable, pwrite, cal_busy, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [9:0]  res [14];
  wire  [9:0]  outv [14];
  int          fails, n_compared, cycles;
  localparam logic [11:0] ofs [14] = '{12'h034, 12'h038, 12'h03c, 12'h040, 12'h044,
    12'h048, 12'h04c, 12'h054, 12'h058, 12'h05c, 12'h060, 12'h064, 12'h068, 12'h06c};
  localparam int wid [14] = '{6, 6, 10, 9, 8, 7, 6, 6, 6, 10, 9, 8, 7, 6};
  localparam logic [11:0] bad [4] = '{12'h050, 12'h030, 12'h070, 12'h035};
  acvb_row_t rows [17] = '{
    '{5'd0, 32'hffffffff, 4'hf, 10'h03f}, '{5'd1, 32'hffffffff, 4'hf, 10'h03f},
    '{5'd2, 32'hffffffff, 4'hf, 10'h3ff}, '{5'd3, 32'hffffffff, 4'hf, 10'h1ff},
    '{5'd4, 32'hffffffff, 4'hf, 10'h0ff}, '{5'd5, 32'hffffffff, 4'hf, 10'h07f},
    '{5'd6, 32'hffffffff, 4'hf, 10'h03f}, '{5'd7, 32'hdeadbeef, 4'hf, 10'h02f},
    '{5'd8, 32'hdeadbeef, 4'hf, 10'h02f}, '{5'd9, 32'hdeadbeef, 4'hf, 10'h2ef},
    '{5'd10, 32'hdeadbeef, 4'hf, 10'h0ef}, '{5'd11, 32'hdeadbeef, 4'hf, 10'h0ef},
    '{5'd12, 32'hdeadbeef, 4'hf, 10'h06f}, '{5'd13, 32'hdeadbeef, 4'hf, 10'h02f},
    '{5'd2, 32'h00000000, 4'h1, 10'h300}, '{5'd9, 32'h00000100, 4'h2, 10'h1ef},
    '{5'd4, 32'h00000000, 4'h0, 10'h0ff}};

  function automatic logic [9:0] msk(int i);
    return 10'((11'h1 << wid[i]) - 11'h1);
  endfunction

  function automatic logic [9:0] calexp(int i);
    return (10'h2a5 ^ 10'(i)) & msk(i);
  endfunction

  // ==========================================================================
  // design under test
  acvb_bank dut (
    .clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cal_busy(cal_busy),
    .plus_cal_d_term_res(res[0][5:0]), .plus_cal_s_term_res(res[1][5:0]),
    .plus_cal_term_four_res(res[2]), .plus_cal_term_three_res(res[3][8:0]),
    .plus_cal_term_two_res(res[4][7:0]), .plus_cal_term_one_res(res[5][6:0]),
    .plus_cal_term_zero_res(res[6][5:0]), .minus_cal_d_term_res(res[7][5:0]),
    .minus_cal_s_term_res(res[8][5:0]), .minus_cal_term_four_res(res[9]),
    .minus_cal_term_three_res(res[10][8:0]), .minus_cal_term_two_res(res[11][7:0]),
    .minus_cal_term_one_res(res[12][6:0]), .minus_cal_term_zero_res(res[13][5:0]),
    .plus_cal_d_term(outv[0][5:0]), .plus_cal_s_term(outv[1][5:0]),
    .plus_cal_term_four(outv[2]), .plus_cal_term_three(outv[3][8:0]),
    .plus_cal_term_two(outv[4][7:0]), .plus_cal_term_one(outv[5][6:0]),
    .plus_cal_term_zero(outv[6][5:0]), .minus_cal_d_term(outv[7][5:0]),
    .minus_cal_s_term(outv[8][5:0]), .minus_cal_term_four(outv[9]),
    .minus_cal_term_three(outv[10][8:0]), .minus_cal_term_two(outv[11][7:0]),
    .minus_cal_term_one(outv[12][6:0]), .minus_cal_term_zero(outv[13][5:0])
  );

  // ==========================================================================
  // clock, timeout and closing
  always #20 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      $display("ERROR %0t: run timed out", $time);
      end_sim();
    end
  end

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ==========================================================================
  // apb transfer, entered just after a rising edge; drop lowers busy in access
  task automatic apb(input logic [11:0] a, input logic wr, input logic [31:0] d,
                     input logic [3:0] s, input logic drop);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      if (pready !== 1'b1 && drop) cal_busy <= 1'b0;
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    clk = 1'b0; rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; pstrb = 4'h0; cal_busy = 1'b0;
    fails = 0; n_compared = 0; cycles = 0;
    foreach (res[i]) res[i] = 10'h000;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 14; i++) begin
      apb(ofs[i], 1'b0, 32'h0, 4'h0, 1'b0);
      `CHK(rd, 32'h0)
      `CHK(outv[i] & msk(i), 10'h000)
    end
    $display("test reset values done");
    foreach (rows[r]) begin
      apb(ofs[rows[r].idx], 1'b1, rows[r].d, rows[r].s, 1'b0);
      apb(ofs[rows[r].idx], 1'b0, 32'h0, 4'h0, 1'b0);
      `CHK(rd, {22'h0, rows[r].e})
      `CHK(err, 1'b0)
      `CHK(outv[rows[r].idx] & msk(rows[r].idx), rows[r].e)
    end
    $display("test register rows done");
    foreach (res[i]) res[i] <= 10'h2a5 ^ 10'(i);
    cal_busy <= 1'b1;
    @(posedge clk);
    cal_busy <= 1'b0;
    repeat (2) @(posedge clk);
    foreach (res[i]) res[i] <= ~res[i];
    repeat (3) @(posedge clk);
    for (int i = 0; i < 14; i++) begin
      apb(ofs[i], 1'b0, 32'h0, 4'h0, 1'b0);
      `CHK(rd, {22'h0, calexp(i)})
      `CHK(outv[i] & msk(i), calexp(i))
    end
    $display("test calibration load done");
    res[0] <= 10'h02a;
    res[7] <= 10'h015;
    cal_busy <= 1'b1;
    apb(ofs[0], 1'b1, 32'h00000015, 4'hf, 1'b1);
    apb(ofs[0], 1'b0, 32'h0, 4'h0, 1'b0);
    `CHK(rd, 32'h0000002a)
    `CHK(outv[7] & msk(7), 10'h015)
    $display("test load against write done");
    foreach (bad[b]) begin
      apb(bad[b], 1'b1, 32'hffffffff, 4'hf, 1'b0);
      `CHK(err, 1'b1)
      apb(bad[b], 1'b0, 32'h0, 4'h0, 1'b0);
      `CHK(err, 1'b1)
      `CHK(rd, 32'h0)
    end
    `CHK(outv[0] & msk(0), 10'h02a)
    `CHK(outv[7] & msk(7), 10'h015)
    $display("test unmapped addresses done");
    rstn <= 1'b0;
    @(negedge clk);
    `CHK(outv[0] & msk(0), 10'h000)
    `CHK(pready, 1'b0)
    @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    apb(ofs[7], 1'b0, 32'h0, 4'h0, 1'b0);
    `CHK(rd, 32'h0)
    $display("test second reset done");
    end_sim();
  end
endmodule
`default_nettype wire

// ### acvb_cal_end.sv
// acvb_cal_end: spots the end of the self-calibration sequence
// assumes: cal_busy is the calibration-in-progress level, synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module acvb_cal_end
  import acvb_pkg::*;
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic cal_busy,
  output logic      end_pulse
);

  // ==========================================================================
  // falling edge of the busy level
  logic busy_q;
  logic busy_d;

  always_comb begin
    busy_d = cal_busy;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
    end
  end

  assign end_pulse = busy_q && !cal_busy;

  // ==========================================================================
  // checks
  a_end_single: assert property (@(posedge clk) disable iff (!rstn)
    end_pulse |=> !end_pulse) else $error("end pulse lasted two cycles");

endmodule
`default_nettype wire

// ### acvb_pkg.sv
// acvb_pkg: constants, register map and helpers of the calibration value bank
// assumes: a 32-bit apb slave with 12-bit byte addresses inside the converter
package acvb_pkg;

  // ==========================================================================
  // value set layout
  localparam int unsigned ACVB_NVAL = 14;
  localparam int unsigned ACVB_MAXW = 10;
  localparam int unsigned ACVB_AW   = 12;
  localparam logic [4:0]  ACVB_NONE = 5'h1f;

  localparam int unsigned IDX_P_D  = 0;
  localparam int unsigned IDX_P_S  = 1;
  localparam int unsigned IDX_P_T4 = 2;
  localparam int unsigned IDX_P_T3 = 3;
  localparam int unsigned IDX_P_T2 = 4;
  localparam int unsigned IDX_P_T1 = 5;
  localparam int unsigned IDX_P_T0 = 6;
  localparam int unsigned IDX_M_D  = 7;
  localparam int unsigned IDX_M_S  = 8;
  localparam int unsigned IDX_M_T4 = 9;
  localparam int unsigned IDX_M_T3 = 10;
  localparam int unsigned IDX_M_T2 = 11;
  localparam int unsigned IDX_M_T1 = 12;
  localparam int unsigned IDX_M_T0 = 13;

  // ==========================================================================
  // field widths and reset value
  localparam int unsigned WID_D  = 6;
  localparam int unsigned WID_S  = 6;
  localparam int unsigned WID_T4 = 10;
  localparam int unsigned WID_T3 = 9;
  localparam int unsigned WID_T2 = 8;
  localparam int unsigned WID_T1 = 7;
  localparam int unsigned WID_T0 = 6;
  localparam logic [9:0]  CAL_RST = 10'h000;

  // ==========================================================================
  // byte offsets
  localparam logic [11:0] OFS_PLUS_D   = 12'h034;
  localparam logic [11:0] OFS_PLUS_S   = 12'h038;
  localparam logic [11:0] OFS_PLUS_T4  = 12'h03c;
  localparam logic [11:0] OFS_PLUS_T3  = 12'h040;
  localparam logic [11:0] OFS_PLUS_T2  = 12'h044;
  localparam logic [11:0] OFS_PLUS_T1  = 12'h048;
  localparam logic [11:0] OFS_PLUS_T0  = 12'h04c;
  localparam logic [11:0] OFS_MINUS_D  = 12'h054;
  localparam logic [11:0] OFS_MINUS_S  = 12'h058;
  localparam logic [11:0] OFS_MINUS_T4 = 12'h05c;
  localparam logic [11:0] OFS_MINUS_T3 = 12'h060;
  localparam logic [11:0] OFS_MINUS_T2 = 12'h064;
  localparam logic [11:0] OFS_MINUS_T1 = 12'h068;
  localparam logic [11:0] OFS_MINUS_T0 = 12'h06c;

  // ==========================================================================
  // apb state machine
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } acvb_apb_st_t;

  // ==========================================================================
  // helpers
  function automatic int unsigned acvb_width(int unsigned idx);
    case (idx % 7)
      0:       return WID_D;
      1:       return WID_S;
      2:       return WID_T4;
      3:       return WID_T3;
      4:       return WID_T2;
      5:       return WID_T1;
      default: return WID_T0;
    endcase
  endfunction

  function automatic logic [11:0] acvb_offset(int unsigned idx);
    case (idx)
      0:       return OFS_PLUS_D;
      1:       return OFS_PLUS_S;
      2:       return OFS_PLUS_T4;
      3:       return OFS_PLUS_T3;
      4:       return OFS_PLUS_T2;
      5:       return OFS_PLUS_T1;
      6:       return OFS_PLUS_T0;
      7:       return OFS_MINUS_D;
      8:       return OFS_MINUS_S;
      9:       return OFS_MINUS_T4;
      10:      return OFS_MINUS_T3;
      11:      return OFS_MINUS_T2;
      12:      return OFS_MINUS_T1;
      default: return OFS_MINUS_T0;
    endcase
  endfunction

  function automatic logic [4:0] acvb_decode(logic [11:0] addr);
    acvb_decode = ACVB_NONE;
    for (int unsigned i = 0; i < ACVB_NVAL; i++) begin
      if (addr == acvb_offset(i)) acvb_decode = 5'(i);
    end
  endfunction

  function automatic logic [31:0] acvb_mask(int unsigned idx);
    return 32'((64'h1 << acvb_width(idx)) - 64'h1);
  endfunction

endpackage

// ### acvb_value_reg.sv
// acvb_value_reg: one calibration value, loaded by calibration or by software
// assumes: load and wr_en are single-cycle strobes from the bank
`timescale 1ns/1ps
`default_nettype none
module acvb_value_reg
  import acvb_pkg::*;
#(
  parameter int unsigned W = 6
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_val,
  output logic      [W-1:0] val_q
);

  // ==========================================================================
  // width check
  if (W < 1 || W > ACVB_MAXW) begin : g_bad_width
    $error("value width out of range");
  end

  // ==========================================================================
  // storage, calibration load before software write
  logic [W-1:0] val_d;

  always_comb begin
    val_d = val_q;
    if (load) begin
      val_d = load_val;
    end else if (wr_en) begin
      val_d = wr_val;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      val_q <= CAL_RST[W-1:0];
    end else begin
      val_q <= val_d;
    end
  end

  // ==========================================================================
  // checks
  a_load_wins: assert property (@(posedge clk) disable iff (!rstn)
    (load && wr_en) |=> (val_q == $past(load_val))) else $error("write beat calibration load");

  a_write_only: assert property (@(posedge clk) disable iff (!rstn)
    (wr_en && !load) |=> (val_q == $past(wr_val))) else $error("software write lost");

endmodule
`default_nettype wire
